//--- rtl/fcs_pkg.sv
// constants and types for the flash command sequencer
// Functional notes
// - chip erase takes 30 ms, array reads FFH
// - no new command while erase runs
// - bit 6 toggles per read during operation
// - first toggle read after command returns one
// - ID entry enters identification mode
// - F000H vendor, F001H macro, F002H size
// - FF7FH reads FFH unless read-protected
// - ID exit returns to array reads
// - protection refuses parallel reads, serial loader; in ID mode, reads off the ID addresses still return array data
// - only chip erase clears read protection
// - protect takes 40 us, blocks commands
// - active operation blocks array reads, fetches
// - writes from flash code are ignored
// - byte program, chip or 4-kbyte erase
// - key 0011B enables command sequences
// - loader entry disables the watchdog
// - command addresses decode lower 12 bits; the FF7FH protect write is compared on all 16 bits
// - key resets to 1100B
// - program takes address, data from cycle four
package fcs_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned ERASE_MS = 30;
  localparam int unsigned PROT_US = 40;
  localparam int unsigned PROG_US = 40;
  localparam int unsigned ERASE_CYC = ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned PROT_CYC = PROT_US * CLK_MHZ;
  localparam int unsigned PROG_CYC = PROG_US * CLK_MHZ;
  localparam int TMR_W = 23;
  // apb map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam int KEY_LSB = 4;
  localparam logic [3:0] KEY_ON = 4'h3;
  localparam logic [3:0] KEY_OFF = 4'hC;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_IDM = 1;
  localparam int ST_RP = 2;
  localparam int ST_STEP = 4;
  localparam int ST_OP = 8;
  // command cycle addresses and data
  localparam logic [11:0] A_555 = 12'h555;
  localparam logic [11:0] A_AAA = 12'hAAA;
  localparam logic [15:0] A_PROT = 16'hFF7F;
  localparam logic [15:0] A_VEND = 16'hF000;
  localparam logic [15:0] A_MACRO = 16'hF001;
  localparam logic [15:0] A_SIZE = 16'hF002;
  localparam logic [7:0] D_AA = 8'hAA;
  localparam logic [7:0] D_55 = 8'h55;
  localparam logic [7:0] D_PROG = 8'hA0;
  localparam logic [7:0] D_ERASE = 8'h80;
  localparam logic [7:0] D_IDIN = 8'h90;
  localparam logic [7:0] D_IDOUT = 8'hF0;
  localparam logic [7:0] D_PROT = 8'hA5;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_SECT = 8'h30;
  localparam logic [7:0] D_ZERO = 8'h00;
  localparam logic [7:0] D_ERASED = 8'hFF;
  localparam int TOG_BIT = 6;
  typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_SECT, OP_CHIP, OP_PROT} fcs_op_t;
endpackage

//--- rtl/fcs_top.sv
// flash command sequencer: unlock decoding, operation timing, id mode, apb control
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fcs_top
  import fcs_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYC, // chip or sector erase time
  parameter int unsigned PROT_CYCLES = PROT_CYC, // read-protect set time
  parameter int unsigned PROG_CYCLES = PROG_CYC, // byte program time
  parameter logic [7:0] VENDOR_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] MACRO_CODE = 8'hC3, // arbitrary value
  parameter logic [7:0] SIZE_CODE = 8'h0E // implemented flash size code
) (
  input wire logic clk_i, // 200 MHz system clock
  input wire logic rst_b_i, // async reset, active low
  // apb slave
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  // core memory bus into flash area
  input wire logic mem_req_i, // access request, held until ack
  input wire logic mem_we_i, // 1 write, 0 read
  input wire logic mem_fetch_i, // read is an instruction fetch
  input wire logic mem_from_flash_i, // issuing code runs from flash
  input wire logic [15:0] mem_addr_i, // byte address
  input wire logic [7:0] mem_wdata_i, // write data
  output logic mem_ack_o, // one-cycle answer pulse
  output logic [7:0] mem_rdata_o, // read data, valid with ack
  // flash array
  output logic [15:0] arr_addr_o, // array read address
  input wire logic [7:0] arr_rdata_i, // array read data, same cycle
  output logic arr_prog_o, // program pulse
  output logic arr_erase_all_o, // chip erase pulse
  output logic arr_erase_sect_o, // sector erase pulse, sector in addr[15:12]
  output logic [15:0] arr_wr_addr_o, // program or sector address
  output logic [7:0] arr_wr_data_o, // program data
  output logic busy_o, // operation running
  // mode and protection
  input wire logic par_mode_i, // parallel programming mode
  input wire logic loader_enter_i, // boot program enters ram loader
  output logic serial_refuse_o, // serial write and loader commands refused
  output logic wdt_off_o // watchdog disable request
);
  typedef struct packed {
    logic [3:0] key;
    logic [2:0] step;
    logic [7:0] cmd;
    fcs_op_t op;
    logic [TMR_W-1:0] tmr;
    logic tog;
    logic rp;
    logic idm;
    logic ack;
    logic [7:0] rdata;
    logic [31:0] prdata;
    logic prog;
    logic erase_all;
    logic erase_sect;
    logic [15:0] waddr;
    logic [7:0] wdata;
    logic wdt_off;
  } fcs_st_t;

  fcs_st_t s_q, s_d;

  // command cycles compare only the low 12 address bits
  function automatic logic cyc_is(input logic [15:0] a, input logic [7:0] d,
                                  input logic [11:0] ea, input logic [7:0] ed);
    cyc_is = (a[11:0] == ea) && (d == ed);
  endfunction

  function automatic logic [TMR_W-1:0] tmr_of(input int unsigned cyc);
    tmr_of = TMR_W'(cyc - 1);
  endfunction

  logic busy;
  logic take;
  logic wr;
  logic rd;
  logic cmd_ok;
  logic apb_setup;
  logic apb_acc;
  logic hit_ctrl;
  logic hit_stat;

  assign busy = (s_q.op != OP_NONE);
  // only fetches wait while busy; data reads pass as polling reads, writes pass too
  assign take = mem_req_i && !s_q.ack && !(busy && mem_fetch_i);
  assign wr = take && mem_we_i;
  assign rd = take && !mem_we_i;
  // key, origin of the code and idle state all gate command decoding
  assign cmd_ok = wr && (s_q.key == KEY_ON) && !mem_from_flash_i && !busy;
  assign apb_setup = psel && !penable;
  assign apb_acc = psel && penable;
  assign hit_ctrl = (paddr == CTRL_OFS);
  assign hit_stat = (paddr == STAT_OFS);

  always_comb begin
    s_d = s_q;
    s_d.ack = take;
    s_d.prog = 1'b0;
    s_d.erase_all = 1'b0;
    s_d.erase_sect = 1'b0;

    // apb register access
    if (apb_setup) begin
      s_d.prdata = '0;
      if (hit_ctrl) begin
        s_d.prdata[KEY_LSB +: 4] = s_q.key;
      end else if (hit_stat) begin
        s_d.prdata[ST_BUSY] = busy;
        s_d.prdata[ST_IDM] = s_q.idm;
        s_d.prdata[ST_RP] = s_q.rp;
        s_d.prdata[ST_STEP +: 3] = s_q.step;
        s_d.prdata[ST_OP +: 3] = s_q.op;
      end
    end
    if (apb_acc && pwrite && hit_ctrl) begin
      // only the two legal key values are stored
      if (pwdata[KEY_LSB +: 4] == KEY_ON || pwdata[KEY_LSB +: 4] == KEY_OFF) begin
        s_d.key = pwdata[KEY_LSB +: 4];
      end
    end

    if (loader_enter_i) begin
      s_d.wdt_off = 1'b1;
    end

    // read path
    if (rd) begin
      if (busy) begin
        // polling reads: first returns one in bit 6, each later read inverts it
        s_d.rdata = D_ZERO;
        s_d.rdata[TOG_BIT] = s_q.tog;
        s_d.tog = !s_q.tog;
      end else if (s_q.idm) begin
        unique case (mem_addr_i)
          A_VEND: s_d.rdata = VENDOR_CODE;
          A_MACRO: s_d.rdata = MACRO_CODE;
          A_SIZE: s_d.rdata = SIZE_CODE;
          A_PROT: s_d.rdata = s_q.rp ? D_ZERO : D_ERASED;
          default: s_d.rdata = arr_rdata_i;
        endcase
      end else if (par_mode_i && s_q.rp) begin
        s_d.rdata = D_ZERO;
      end else begin
        s_d.rdata = arr_rdata_i;
      end
    end

    // operation timer
    if (busy) begin
      if (s_q.tmr == '0) begin
        if (s_q.op == OP_PROT) begin
          s_d.rp = 1'b1;
        end
        if (s_q.op == OP_CHIP) begin
          s_d.rp = 1'b0;
        end
        s_d.op = OP_NONE;
      end else begin
        s_d.tmr = s_q.tmr - 1'b1;
      end
    end

    // command sequence decoder; any deviation restarts at step 0
    if (wr && !cmd_ok) begin
      s_d.step = '0;
    end
    if (cmd_ok) begin
      s_d.step = '0;
      unique case (s_q.step)
        3'd0: begin
          if (cyc_is(mem_addr_i, mem_wdata_i, A_555, D_AA)) begin
            s_d.step = 3'd1;
          end else if (mem_wdata_i == D_IDOUT) begin
            s_d.idm = 1'b0;
          end
        end
        3'd1: begin
          if (cyc_is(mem_addr_i, mem_wdata_i, A_AAA, D_55)) begin
            s_d.step = 3'd2;
          end
        end
        3'd2: begin
          if (mem_addr_i[11:0] == A_555) begin
            s_d.cmd = mem_wdata_i;
            unique case (mem_wdata_i)
              D_PROG, D_ERASE, D_PROT: s_d.step = 3'd3;
              D_IDIN: s_d.idm = 1'b1;
              D_IDOUT: s_d.idm = 1'b0;
              default: s_d.step = '0;
            endcase
          end
        end
        3'd3: begin
          if (s_q.cmd == D_PROG) begin
            // single byte per sequence, taken from the fourth write
            s_d.waddr = mem_addr_i;
            s_d.wdata = mem_wdata_i;
            s_d.prog = 1'b1;
            s_d.op = OP_PROG;
            s_d.tmr = tmr_of(PROG_CYCLES);
            s_d.tog = 1'b1;
          end else if (s_q.cmd == D_PROT) begin
            if (mem_addr_i == A_PROT && mem_wdata_i == D_ZERO) begin
              s_d.op = OP_PROT;
              s_d.tmr = tmr_of(PROT_CYCLES);
              s_d.tog = 1'b1;
            end
          end else if (cyc_is(mem_addr_i, mem_wdata_i, A_555, D_AA)) begin
            s_d.step = 3'd4;
          end
        end
        3'd4: begin
          if (cyc_is(mem_addr_i, mem_wdata_i, A_AAA, D_55)) begin
            s_d.step = 3'd5;
          end
        end
        3'd5: begin
          if (cyc_is(mem_addr_i, mem_wdata_i, A_555, D_CHIP)) begin
            s_d.erase_all = 1'b1;
            s_d.op = OP_CHIP;
            s_d.tmr = tmr_of(ERASE_CYCLES);
            s_d.tog = 1'b1;
          end else if (mem_wdata_i == D_SECT) begin
            // sector chosen by the upper four address bits
            s_d.waddr = mem_addr_i;
            s_d.erase_sect = 1'b1;
            s_d.op = OP_SECT;
            s_d.tmr = tmr_of(ERASE_CYCLES);
            s_d.tog = 1'b1;
          end
        end
        default: s_d.step = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.key <= KEY_OFF;
      s_q.op <= OP_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = 1'b1;
  assign pslverr = apb_acc && !(hit_ctrl || hit_stat);
  assign mem_ack_o = s_q.ack;
  assign mem_rdata_o = s_q.rdata;
  assign arr_addr_o = mem_addr_i;
  assign arr_prog_o = s_q.prog;
  assign arr_erase_all_o = s_q.erase_all;
  assign arr_erase_sect_o = s_q.erase_sect;
  assign arr_wr_addr_o = s_q.waddr;
  assign arr_wr_data_o = s_q.wdata;
  assign busy_o = busy;
  assign serial_refuse_o = s_q.rp;
  assign wdt_off_o = s_q.wdt_off;
endmodule
`default_nettype wire

//--- sim/fcs_arr_model.sv
// behavioural flash array behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module fcs_arr_model (
  input wire logic clk_i, // system clock
  input wire logic [15:0] arr_addr_o, // read address
  input wire logic arr_prog_o, arr_erase_all_o, arr_erase_sect_o, // pulses
  input wire logic [15:0] arr_wr_addr_o, // target address
  input wire logic [7:0] arr_wr_data_o, // program data
  output logic [7:0] arr_rdata_i // read data
);
  logic [7:0] mem [logic [15:0]];
  bit erased = 0;
  bit upd = 0;
  // unwritten bytes hold an address pattern until the first chip erase
  function automatic logic [7:0] rd(input logic [15:0] a);
    if (mem.exists(a)) return mem[a];
    return erased ? 8'hFF : a[7:0] ^ 8'h5A;
  endfunction
  always @(arr_addr_o, upd) arr_rdata_i = rd(arr_addr_o);
  always @(posedge clk_i) begin
    if (arr_erase_all_o) begin
      mem.delete();
      erased = 1;
    end
    if (arr_erase_sect_o) for (int i = 0; i < 4096; i++) mem[{arr_wr_addr_o[15:12], 12'(i)}] = 8'hFF;
    // programming can only clear bits, as a real cell does
    if (arr_prog_o) mem[arr_wr_addr_o] = rd(arr_wr_addr_o) & arr_wr_data_o;
    upd = ~upd;
  end
endmodule
`default_nettype wire

//--- sim/fcs_sva.sv
// port assertions for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module fcs_sva #(parameter int unsigned ERASE_CYCLES = 20) (
  input wire logic clk_i, rst_b_i, psel, penable, pslverr, mem_req_i, mem_we_i,
  input wire logic mem_fetch_i, mem_ack_o, arr_prog_o, arr_erase_all_o, busy_o,
  input wire logic par_mode_i, loader_enter_i, serial_refuse_o, wdt_off_o, arr_erase_sect_o,
  input wire logic [7:0] mem_rdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  int unsigned run_q;
  // a stuck timer shows up as an over-long busy stretch
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i) run_q <= 0;
    else run_q <= busy_o ? run_q + 1 : 0;
  ack_one_cycle_a: assert property (mem_ack_o |=> !mem_ack_o)
    else $error("ack held too long");
  fetch_stall_a: assert property (busy_o && mem_req_i && mem_fetch_i && !mem_ack_o |=> !mem_ack_o)
    else $error("fetch answered while busy");
  busy_toggle_a: assert property (busy_o && mem_req_i && !mem_we_i && !mem_fetch_i && !mem_ack_o
    |=> mem_ack_o && (mem_rdata_o & 8'hBF) == 8'h00)
    else $error("busy read not toggle only");
  prot_read_a: assert property (!busy_o && mem_req_i && !mem_we_i && !mem_ack_o && par_mode_i
    && serial_refuse_o |=> mem_rdata_o == 8'h00)
    else $error("protected parallel read leaked");
  erase_busy_a: assert property (arr_erase_all_o |=> busy_o [*8])
    else $error("erase not busy");
  prog_busy_a: assert property (arr_prog_o |=> busy_o [*5])
    else $error("program not busy");
  busy_len_a: assert property (run_q <= ERASE_CYCLES + 4)
    else $error("busy too long");
  prot_clear_a: assert property ($fell(serial_refuse_o) |-> $past(busy_o))
    else $error("protection cleared without erase");
  wdt_sticky_a: assert property (loader_enter_i |=> wdt_off_o [*3])
    else $error("watchdog not disabled");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  cover property (arr_erase_all_o);
  cover property (arr_prog_o);
  cover property (arr_erase_sect_o);
  cover property (busy_o && mem_ack_o);
endmodule
bind fcs_top fcs_sva #(.ERASE_CYCLES(ERASE_CYCLES)) u_sva (.*);
`default_nettype wire

//--- sim/fcs_top_tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module fcs_top_tb;
  import fcs_pkg::*;
  localparam logic [7:0] VEN = 8'h3C; // arbitrary value
  localparam logic [7:0] MAC = 8'h96; // arbitrary value
  localparam logic [7:0] SIZ = 8'h0E;
  logic clk_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, mem_ack_o, busy_o, serial_refuse_o, wdt_off_o;
  logic mem_req_i = 0, mem_we_i = 0, mem_fetch_i = 0, mem_from_flash_i = 0;
  logic par_mode_i = 0, loader_enter_i = 0, arr_prog_o, arr_erase_all_o, arr_erase_sect_o;
  logic [15:0] mem_addr_i = 0, arr_addr_o, arr_wr_addr_o, ta;
  logic [7:0] mem_wdata_i = 0, mem_rdata_o, arr_rdata_i, arr_wr_data_o, td;
  logic [32:0] exp_q[$];
  int err_count = 0, comparisons = 0;
  always #2.5 clk_i = ~clk_i;
  fcs_top #(.ERASE_CYCLES(60), .PROT_CYCLES(10), .PROG_CYCLES(10), .VENDOR_CODE(VEN),
    .MACRO_CODE(MAC), .SIZE_CODE(SIZ)) u_dut (.*);
  fcs_arr_model u_arr (.*);
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic mem(input logic we, input logic f, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    if (!we) exp_q.push_back({25'h0, d});
    @(posedge clk_i);
    mem_req_i <= 1;
    mem_we_i <= we;
    mem_fetch_i <= f;
    mem_addr_i <= a;
    mem_wdata_i <= d;
    do begin
      @(negedge clk_i);
      n++;
    end while (!mem_ack_o && n < 200);
    if (n >= 200) err_count++;
    @(posedge clk_i);
    mem_req_i <= 0;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    @(posedge clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= e[31:0];
    @(posedge clk_i);
    penable <= 1;
    do @(negedge clk_i); while (!pready);
    @(posedge clk_i);
    psel <= 0;
    penable <= 0;
  endtask
  // command writes never come with fetches, as with the interrupt master enable cleared
  task automatic unlock(input logic [7:0] d);
    mem(1, 0, {4'($urandom), A_555}, D_AA);
    mem(1, 0, {4'($urandom), A_AAA}, D_55);
    mem(1, 0, {4'($urandom), A_555}, d);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (busy_o && n < 100);
    if (n >= 100) err_count++;
  endtask
  always @(negedge clk_i) begin
    if (mem_ack_o && !mem_we_i) chk({25'h0, mem_rdata_o}, exp_q.pop_front());
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    #50us;
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(18));
    ta = 16'($urandom);
    td = 8'($urandom);
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1;
    apb(0, CTRL_OFS, 33'h0C0);
    apb(0, 12'h008, {1'b1, 32'h0});
    unlock(D_PROG);
    mem(1, 0, ta, td);
    mem(0, 0, ta, ta[7:0] ^ 8'h5A);
    apb(1, CTRL_OFS, {25'h0, KEY_ON, 4'h0});
    unlock(D_IDIN);
    mem(0, 0, A_VEND, VEN);
    mem(0, 0, A_MACRO, MAC);
    mem(0, 0, A_SIZE, SIZ);
    mem(0, 0, A_PROT, D_ERASED);
    mem(1, 0, 16'h0000, D_IDOUT);
    mem(0, 0, A_VEND, A_VEND[7:0] ^ 8'h5A);
    mem_from_flash_i <= 1;
    unlock(D_PROG);
    mem(1, 0, ta, td);
    mem_from_flash_i <= 0;
    mem(0, 0, ta, ta[7:0] ^ 8'h5A);
    unlock(D_ERASE);
    unlock(D_CHIP);
    mem(0, 0, ta, 8'h40);
    mem(0, 0, ta, 8'h00);
    unlock(D_PROG);
    mem(1, 0, ta, ~td);
    mem(0, 1, ta ^ 16'h0001, D_ERASED);
    mem(0, 0, ta, D_ERASED);
    unlock(D_PROG);
    mem(1, 0, ta, td);
    mem(0, 0, ta, 8'h40);
    idle();
    mem(0, 0, ta, td);
    unlock(D_ERASE);
    mem(1, 0, {4'($urandom), A_555}, D_AA);
    mem(1, 0, {4'($urandom), A_AAA}, D_55);
    mem(1, 0, ta, D_SECT);
    mem(0, 0, ta, 8'h40);
    idle();
    mem(0, 0, ta, D_ERASED);
    unlock(D_ERASE);
    unlock(8'h12);
    chk({32'h0, busy_o}, 33'h0);
    unlock(D_PROT);
    mem(1, 0, A_PROT, D_ZERO);
    mem(0, 0, A_PROT, 8'h40);
    idle();
    chk({32'h0, serial_refuse_o}, 33'h1);
    par_mode_i <= 1;
    mem(0, 0, ta, 8'h00);
    par_mode_i <= 0;
    unlock(D_IDIN);
    mem(0, 0, A_PROT, 8'h00);
    unlock(D_IDOUT);
    unlock(D_ERASE);
    unlock(D_CHIP);
    mem(0, 0, ta, 8'h40);
    idle();
    chk({32'h0, serial_refuse_o}, 33'h0);
    apb(1, CTRL_OFS, {25'h0, KEY_OFF, 4'h0});
    apb(0, CTRL_OFS, 33'h0C0);
    loader_enter_i <= 1;
    @(posedge clk_i);
    loader_enter_i <= 0;
    @(negedge clk_i);
    chk({32'h0, wdt_off_o}, 33'h1);
    conclude();
  end
endmodule
`default_nettype wire
